/* lpc_burst_pwm.v */
/*
  Internal burst dimming generator: 128 steps per period, duty in steps.
  Assumes restart_in is a one-cycle pulse from an external dimming clock
  edge; in internal mode the period free-runs on the step divider.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defines.vh"

module lpc_burst_pwm #(
  parameter STEP_CYC = `LPC_BURST_STEP_CYC
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire ext_mode_in,
  input wire restart_in,
  input wire [6:0] duty_in,
  output reg pwm_out
);

  reg [15:0] div_q;
  reg [6:0] step_q;
  wire step_en = (div_q == STEP_CYC[15:0] - 16'h0001);

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      div_q <= 16'h0000;
      step_q <= 7'h00;
      pwm_out <= 1'b0;
    end
    else
    begin
      // an external clock edge realigns the period to the outside source
      if (ext_mode_in && restart_in)
      begin
        div_q <= 16'h0000;
        step_q <= 7'h00;
      end
      else if (step_en)
      begin
        div_q <= 16'h0000;
        // in external mode hold at the last step until the next edge
        if (!(ext_mode_in && step_q == 7'h7F))
          step_q <= step_q + 7'h01;
      end
      else
        div_q <= div_q + 16'h0001;
      pwm_out <= (step_q < duty_in);
    end
  end

endmodule // lpc_burst_pwm
`default_nettype wire

/* lpc_defines.vh */
/*
  Constants for the lamp pin control block: register offsets, field
  positions, reset values and timing counts.
  Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef LPC_DEFINES_VH
`define LPC_DEFINES_VH

`define LPC_CLK_HZ 200000000
`define LPC_ADDR_W 8

// register byte offsets
`define LPC_REG_CTRL2 8'h00
`define LPC_REG_OVD_CFG 8'h04
`define LPC_REG_EMI_CTRL 8'h08
`define LPC_REG_LAMP_DIV 8'h0C
`define LPC_REG_BURST_DUTY 8'h10
`define LPC_REG_STATE 8'h14
`define LPC_REG_IRQ_STAT 8'h18
`define LPC_REG_IRQ_CLR 8'h1C
`define LPC_REG_IRQ_EN 8'h20

// second control register fields
`define LPC_C2_LAMP_OFF 0
`define LPC_C2_LAMP_RX 1
`define LPC_C2_BURST_RX 2
`define LPC_C2_BURST_EXT 3
`define LPC_CTRL2_RST 4'h0

// overdrive configuration fields
`define LPC_OVD_EN 0
`define LPC_OVD_AMT_LSB 4
`define LPC_OVD_AMT_MSB 7
`define LPC_OVD_RST 8'h00

// emi control fields: amount code 0..3 means 1..4 percent
`define LPC_EMI_EN 0
`define LPC_EMI_UP 1
`define LPC_EMI_AMT_LSB 2
`define LPC_EMI_AMT_MSB 3
`define LPC_EMI_RST 4'h0

// lamp oscillator half period in clocks: 1250 gives 80 kHz
`define LPC_LAMP_DIV_RST 16'h04E2
`define LPC_BURST_DUTY_RST 7'h40

// interrupt status bits
`define LPC_IRQ_W 3
`define LPC_IRQ_CTRL_RST 0
`define LPC_IRQ_FAULT 1
`define LPC_IRQ_LAMP_OFF 2

// synchronised input bit positions
`define LPC_SYN_W 8
`define LPC_SYN_OFF 0
`define LPC_SYN_OVD 1
`define LPC_SYN_SHIFT 2
`define LPC_SYN_LAMP_FREQ_SYNC_PIN 3
`define LPC_SYN_BSYNC 4
`define LPC_SYN_BOSC 5
`define LPC_SYN_ADDR 6
`define LPC_SYN_FAULT 7
// lamp-off stage resets to off so no false strike fires before the pin is seen
`define LPC_SYN_RST 8'h01

// nominal internal burst frequency, 128 steps per period
`define LPC_BURST_HZ 200
`define LPC_BURST_STEPS 128
`define LPC_BURST_STEP_CYC (`LPC_CLK_HZ / (`LPC_BURST_HZ * `LPC_BURST_STEPS))

`define LPC_RESP_OKAY 2'h0
`define LPC_RESP_SLVERR 2'h2

`endif

/* lpc_host_model.sv */
/* far side: sibling controllers sourcing the sync wires while the block
   listens, and a board dimming clock; assumes wires resolve here */
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model #(
  parameter LHALF = 7,
  parameter BHALF = 23,
  parameter OSC_PER = 40
) (
  input wire logic clk_in,
  input wire logic osc_run_in,
  input wire logic lamp_oe_in,
  input wire logic lamp_dat_in,
  input wire logic burst_oe_in,
  input wire logic burst_dat_in,
  output logic lamp_wire_out,
  output logic burst_wire_out,
  output logic osc_out
);
  int lc = 0;
  int bc = 0;
  int oc = 0;
  logic lsib = 1'h0;
  logic bsib = 1'h0;
  logic osc_q = 1'h0;
  always @(posedge clk_in)
  begin
    lc <= (lc == LHALF - 1) ? 0 : lc + 1;
    bc <= (bc == BHALF - 1) ? 0 : bc + 1;
    if (lc == LHALF - 1)
      lsib <= ~lsib;
    if (bc == BHALF - 1)
      bsib <= ~bsib;
    // dimming clock stands still when not wanted
    oc <= (!osc_run_in || oc == OSC_PER - 1) ? 0 : oc + 1;
    osc_q <= osc_run_in && oc < OSC_PER / 2;
  end
  // siblings drive only while the block listens
  assign lamp_wire_out = lamp_oe_in ? lamp_dat_in : lsib;
  assign burst_wire_out = burst_oe_in ? burst_dat_in : bsib;
  assign osc_out = osc_q;
endmodule // lpc_host_model
`default_nettype wire

/* lpc_pin_ctrl.v */
/*
  Pin-level control of a dual-channel lamp controller: lamp on/off with
  controller reset, current overdrive, lamp frequency step, lamp and
  burst sync source/receiver selection, fault output, AXI4-Lite registers
  and one level interrupt.
  Assumes all pins are asynchronous inputs, synchronised to clk_in by two flops; two-way pins
  are split into input, output and output enable, resolved outside.
*/
// What this block does
// - lamp-off request low turns the lamps on
// - lamp-off request high: lamps off, fault cleared, power-down held
// - falling lamp-off request resets controller, clears fault, restarts strike
// - effective lamp-off is pin OR register lamp-off bit
// - overdrive request high enables overdrive by configured amount, else nominal
// - effective overdrive is pin OR overdrive enable bit
// - shift request moves lamp frequency up or down one to four percent
// - effective shift request is pin OR shift enable bit
// - lamp frequency receiver takes frequency from lamp sync pin input
// - lamp frequency source drives internal lamp frequency on sync pin
// - burst receiver takes its burst signal from burst sync pin input
// - burst source drives internal burst signal on burst sync pin
// - external 22.5 to 440 Hz burst clock times internal burst signal
// - second address select pin level sets the serial slave address
// - faults shown on active-low open-drain error output
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defines.vh"

module lpc_pin_ctrl #(
  parameter BURST_STEP_CYC = `LPC_BURST_STEP_CYC
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire lamp_off_request_in,
  input wire overdrive_request_in,
  input wire freq_shift_request_in,
  input wire lamp_freq_sync_pin_in,
  output reg lamp_freq_sync_pin_out,
  output reg lamp_freq_sync_pin_oe_out,
  input wire burst_sync_pin_in,
  output reg burst_sync_pin_out,
  output reg burst_sync_pin_oe_out,
  input wire burst_osc_pin_in,
  input wire addr_select_1_in,
  input wire fault_detect_in,
  output reg fault_n_out,
  output reg fault_n_oe_out,
  output reg lamp_enable_out,
  output reg strike_start_out,
  output reg overdrive_active_out,
  output reg [3:0] overdrive_amount_out,
  output reg lamp_clk_out,
  output reg burst_dimming_pwm_out,
  output reg addr_select_1_out,
  output reg irq_out,
  input wire [`LPC_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`LPC_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // byte-lane merge of a write into a register of up to 16 bits
  function [15:0] lpc_merge;
    input [15:0] old_val;
    input [31:0] wdata;
    input [3:0] strb;
    begin
      lpc_merge = old_val;
      if (strb[0])
        lpc_merge[7:0] = wdata[7:0];
      if (strb[1])
        lpc_merge[15:8] = wdata[15:8];
    end
  endfunction

  // half period moved by (code+1) percent, up means shorter period
  function [15:0] lpc_shift;
    input [15:0] base;
    input up;
    input [1:0] code;
    reg [18:0] prod;
    reg [18:0] delta;
    begin
      prod = base * ({1'b0, code} + 3'h1);
      delta = prod[18:0] / 19'd100;
      lpc_shift = up ? (base - delta[15:0]) : (base + delta[15:0]);
    end
  endfunction

  wire [`LPC_SYN_W-1:0] syn;
  reg [3:0] ctrl2_q;
  reg [7:0] ovd_cfg_q;
  reg [3:0] emi_q;
  reg [15:0] lamp_div_q;
  reg [6:0] duty_q;
  reg [`LPC_IRQ_W-1:0] irq_stat_q;
  reg [`LPC_IRQ_W-1:0] irq_en_q;
  reg off_eff_q;
  reg bosc_q;
  reg fault_q;
  reg [15:0] lamp_cnt_q;
  reg lamp_int_q;
  reg aw_full_q;
  reg w_full_q;
  reg [`LPC_ADDR_W-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire burst_int;

  // synchronise pins; lamp-off reads as off until really sampled
  lpc_sync #(.RST_VAL(`LPC_SYN_RST)) u_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .async_in({fault_detect_in, addr_select_1_in, burst_osc_pin_in, burst_sync_pin_in,
      lamp_freq_sync_pin_in, freq_shift_request_in, overdrive_request_in,
      lamp_off_request_in}),
    .sync_out(syn)
  );

  wire off_eff = syn[`LPC_SYN_OFF] | ctrl2_q[`LPC_C2_LAMP_OFF];
  wire ctrl_reset = off_eff_q & ~off_eff;
  wire off_rise = ~off_eff_q & off_eff;
  wire ovd_eff = syn[`LPC_SYN_OVD] | ovd_cfg_q[`LPC_OVD_EN];
  wire shift_eff = syn[`LPC_SYN_SHIFT] | emi_q[`LPC_EMI_EN];
  wire bosc_rise = syn[`LPC_SYN_BOSC] & ~bosc_q;
  wire fault_set = syn[`LPC_SYN_FAULT] & ~off_eff & ~ctrl_reset & ~fault_q;

  wire [15:0] half_per = shift_eff ?
    lpc_shift(lamp_div_q, emi_q[`LPC_EMI_UP], emi_q[`LPC_EMI_AMT_MSB:`LPC_EMI_AMT_LSB]) :
    lamp_div_q;

  // generator of the internal burst signal, timed by the step divider or dimming clock
  lpc_burst_pwm #(
    .STEP_CYC(BURST_STEP_CYC)
  ) u_burst (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .ext_mode_in(ctrl2_q[`LPC_C2_BURST_EXT]),
    .restart_in(bosc_rise),
    .duty_in(duty_q),
    .pwm_out(burst_int)
  );

  // control and output flops
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      off_eff_q <= 1'b1;
      bosc_q <= 1'b0;
      fault_q <= 1'b0;
      lamp_cnt_q <= 16'h0000;
      lamp_int_q <= 1'b0;
      lamp_enable_out <= 1'b0;
      strike_start_out <= 1'b0;
      overdrive_active_out <= 1'b0;
      overdrive_amount_out <= 4'h0;
      lamp_clk_out <= 1'b0;
      burst_dimming_pwm_out <= 1'b0;
      lamp_freq_sync_pin_out <= 1'b0;
      lamp_freq_sync_pin_oe_out <= 1'b0;
      burst_sync_pin_out <= 1'b0;
      burst_sync_pin_oe_out <= 1'b0;
      fault_n_out <= 1'b0;
      fault_n_oe_out <= 1'b0;
      addr_select_1_out <= 1'b0;
      irq_out <= 1'b0;
    end
    else
    begin
      off_eff_q <= off_eff;
      bosc_q <= syn[`LPC_SYN_BOSC];
      lamp_enable_out <= ~off_eff;
      strike_start_out <= ctrl_reset;
      if (off_eff || ctrl_reset)
        fault_q <= 1'b0;
      else if (syn[`LPC_SYN_FAULT])
        fault_q <= 1'b1;
      // open drain, pulls low only on fault
      fault_n_oe_out <= fault_q;
      overdrive_active_out <= ovd_eff;
      overdrive_amount_out <= ovd_eff ? ovd_cfg_q[`LPC_OVD_AMT_MSB:`LPC_OVD_AMT_LSB] : 4'h0;
      if (lamp_cnt_q >= half_per - 16'h0001)
      begin
        lamp_cnt_q <= 16'h0000;
        lamp_int_q <= ~lamp_int_q;
      end
      else
        lamp_cnt_q <= lamp_cnt_q + 16'h0001;
      lamp_clk_out <= ctrl2_q[`LPC_C2_LAMP_RX] ? syn[`LPC_SYN_LAMP_FREQ_SYNC_PIN] : lamp_int_q;
      lamp_freq_sync_pin_out <= lamp_int_q;
      lamp_freq_sync_pin_oe_out <= ~ctrl2_q[`LPC_C2_LAMP_RX];
      burst_dimming_pwm_out <= ctrl2_q[`LPC_C2_BURST_RX] ? syn[`LPC_SYN_BSYNC] : burst_int;
      burst_sync_pin_out <= burst_int;
      burst_sync_pin_oe_out <= ~ctrl2_q[`LPC_C2_BURST_RX];
      addr_select_1_out <= syn[`LPC_SYN_ADDR];
      irq_out <= |(irq_stat_q & irq_en_q);
    end
  end

  // interrupt status, set wins over clear
  wire wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire [`LPC_IRQ_W-1:0] irq_set = {off_rise, fault_set, ctrl_reset};
  wire [`LPC_IRQ_W-1:0] irq_clr = (wr_go && aw_addr_q == `LPC_REG_IRQ_CLR && w_strb_q[0]) ?
    w_data_q[`LPC_IRQ_W-1:0] : {`LPC_IRQ_W{1'b0}};

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      irq_stat_q <= {`LPC_IRQ_W{1'b0}};
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
  end

  // write channel: address and data taken in either order
  reg wr_hit;
  always @*
  begin
    case (aw_addr_q)
      `LPC_REG_CTRL2, `LPC_REG_OVD_CFG, `LPC_REG_EMI_CTRL, `LPC_REG_LAMP_DIV,
      `LPC_REG_BURST_DUTY, `LPC_REG_IRQ_CLR, `LPC_REG_IRQ_EN:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= {`LPC_ADDR_W{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LPC_RESP_OKAY;
      ctrl2_q <= `LPC_CTRL2_RST;
      ovd_cfg_q <= `LPC_OVD_RST;
      emi_q <= `LPC_EMI_RST;
      lamp_div_q <= `LPC_LAMP_DIV_RST;
      duty_q <= `LPC_BURST_DUTY_RST;
      irq_en_q <= {`LPC_IRQ_W{1'b0}};
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_q <= {s_axi_awaddr[`LPC_ADDR_W-1:2], 2'b00};
        aw_full_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        case (aw_addr_q)
          `LPC_REG_CTRL2:
            ctrl2_q <= w_strb_q[0] ? w_data_q[3:0] : ctrl2_q;
          `LPC_REG_OVD_CFG:
            ovd_cfg_q <= w_strb_q[0] ? (w_data_q[7:0] & 8'hF1) : ovd_cfg_q;
          `LPC_REG_EMI_CTRL:
            emi_q <= w_strb_q[0] ? w_data_q[3:0] : emi_q;
          `LPC_REG_LAMP_DIV:
            lamp_div_q <= lpc_merge(lamp_div_q, w_data_q, w_strb_q);
          `LPC_REG_BURST_DUTY:
            duty_q <= w_strb_q[0] ? w_data_q[6:0] : duty_q;
          `LPC_REG_IRQ_EN:
            irq_en_q <= w_strb_q[0] ? w_data_q[`LPC_IRQ_W-1:0] : irq_en_q;
          default:
            ;
        endcase
      end
      // accept the next pair only once the response is taken
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel
  reg [31:0] rd_val;
  reg rd_hit;
  always @*
  begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[`LPC_ADDR_W-1:2], 2'b00})
      `LPC_REG_CTRL2:
        rd_val[3:0] = ctrl2_q;
      `LPC_REG_OVD_CFG:
        rd_val[7:0] = ovd_cfg_q;
      `LPC_REG_EMI_CTRL:
        rd_val[3:0] = emi_q;
      `LPC_REG_LAMP_DIV:
        rd_val[15:0] = lamp_div_q;
      `LPC_REG_BURST_DUTY:
        rd_val[6:0] = duty_q;
      `LPC_REG_STATE:
        rd_val[5:0] = {fault_q, addr_select_1_out, lamp_clk_out, shift_eff,
          overdrive_active_out, lamp_enable_out};
      `LPC_REG_IRQ_STAT:
        rd_val[`LPC_IRQ_W-1:0] = irq_stat_q;
      `LPC_REG_IRQ_CLR:
        rd_val = 32'h00000000;
      `LPC_REG_IRQ_EN:
        rd_val[`LPC_IRQ_W-1:0] = irq_en_q;
      default:
        rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LPC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // lpc_pin_ctrl
`default_nettype wire

/* lpc_pin_ctrl_assertions.sv */
/* checker for lpc_pin_ctrl: lamp, fault, overdrive and bus timing
   assumes it is bound to lpc_pin_ctrl, one clock domain */
`timescale 1ns/1ps
`default_nettype none
module lpc_chk (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic lamp_off_request_in,
  input wire logic overdrive_request_in,
  input wire logic fault_detect_in,
  input wire logic fault_n_out,
  input wire logic fault_n_oe_out,
  input wire logic lamp_enable_out,
  input wire logic strike_start_out,
  input wire logic overdrive_active_out,
  input wire logic [3:0] overdrive_amount_out,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  off_lamp_dark_a: assert property
    (lamp_off_request_in [*4] |-> !lamp_enable_out)
    else $error("lamps on while off requested");
  on_strike_seen_a: assert property
    ($rose(lamp_enable_out) |-> ##[0:2] $past(strike_start_out))
    else $error("lamps on without controller reset");
  strike_pulse_a: assert property
    (strike_start_out |=> !strike_start_out)
    else $error("strike pulse too long");
  off_fault_clear_a: assert property
    (!lamp_enable_out [*3] |-> !fault_n_oe_out)
    else $error("fault held while lamps off");
  fault_latch_a: assert property
    ((lamp_enable_out && fault_detect_in && !lamp_off_request_in) [*7]
      |=> fault_n_oe_out || !lamp_enable_out)
    else $error("fault not flagged");
  fault_drive_low_a: assert property
    (fault_n_oe_out |-> !fault_n_out)
    else $error("fault pin driven high");
  ovd_pin_on_a: assert property
    (overdrive_request_in [*4] |-> overdrive_active_out)
    else $error("overdrive pin ignored");
  ovd_amt_zero_a: assert property
    (!overdrive_active_out |-> overdrive_amount_out == 4'h0)
    else $error("overdrive amount while nominal");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken before response");
  strike_c: cover property (strike_start_out);
  fault_c: cover property ($rose(fault_n_oe_out));
  ovd_c: cover property (overdrive_active_out && overdrive_amount_out != 4'h0);
endmodule // lpc_chk
bind lpc_pin_ctrl lpc_chk i_chk (.clk_in, .arst_n_in, .lamp_off_request_in,
  .overdrive_request_in, .fault_detect_in, .fault_n_out, .fault_n_oe_out, .lamp_enable_out,
  .strike_start_out, .overdrive_active_out, .overdrive_amount_out, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* lpc_sync.v */
/*
  Two-flop synchroniser for the block's pin inputs.
  Assumes the inputs are slow levels relative to the 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defines.vh"

module lpc_sync #(
  parameter [`LPC_SYN_W-1:0] RST_VAL = {`LPC_SYN_W{1'b0}}
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire [`LPC_SYN_W-1:0] async_in,
  output reg [`LPC_SYN_W-1:0] sync_out
);

  reg [`LPC_SYN_W-1:0] meta_q;

  // the first stage feeds only the second
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      // reset level per bit, matching each pin's idle meaning
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // lpc_sync
`default_nettype wire

/* testbench.sv */
/* self-checking bench for lpc_pin_ctrl with a register reference model
   assumes lpc_host_model stands on the far side of the sync pins */
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defines.vh"
module testbench;
  localparam int STEP = 4;
  logic clk_in = 1'h0;
  logic arst_n_in = 1'h0;
  logic off_q = 1'h0, ovd_q = 1'h0, shf_q = 1'h0, flt_q = 1'h0, adr_q = 1'h0, osc_run = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd_q;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0] amt;
  wire awready, wready, bvalid, arready, rvalid, lsy_o, lsy_oe, bsy_o, bsy_oe, lsy_w, bsy_w;
  wire osc_w, lamp_en, strike, ovd_act, lclk, bpwm, adr_o, irq, fn, fn_oe;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] ovd_amt;
  int err_total = 0, n_tests = 0, strikes = 0;
  int exp_q[9] = '{0, 0, 0, `LPC_LAMP_DIV_RST, `LPC_BURST_DUTY_RST, 0, 0, 0, 0};
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in)
    if (strike === 1'h1)
      strikes <= strikes + 1;
  lpc_pin_ctrl #(.BURST_STEP_CYC(STEP)) i_dut (.clk_in, .arst_n_in,
    .lamp_off_request_in(off_q), .overdrive_request_in(ovd_q), .freq_shift_request_in(shf_q),
    .lamp_freq_sync_pin_in(lsy_w), .lamp_freq_sync_pin_out(lsy_o),
    .lamp_freq_sync_pin_oe_out(lsy_oe), .burst_sync_pin_in(bsy_w), .burst_sync_pin_out(bsy_o),
    .burst_sync_pin_oe_out(bsy_oe), .burst_osc_pin_in(osc_w), .addr_select_1_in(adr_q),
    .fault_detect_in(flt_q), .fault_n_out(fn), .fault_n_oe_out(fn_oe),
    .lamp_enable_out(lamp_en), .strike_start_out(strike), .overdrive_active_out(ovd_act),
    .overdrive_amount_out(ovd_amt), .lamp_clk_out(lclk), .burst_dimming_pwm_out(bpwm),
    .addr_select_1_out(adr_o), .irq_out(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  lpc_host_model i_far (.clk_in, .osc_run_in(osc_run), .lamp_oe_in(lsy_oe),
    .lamp_dat_in(lsy_o), .burst_oe_in(bsy_oe), .burst_dat_in(bsy_o),
    .lamp_wire_out(lsy_w), .burst_wire_out(bsy_w), .osc_out(osc_w));
  task chk(input string s, input logic [31:0] got, input logic [31:0] e);
    n_tests++;
    if (got !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, got);
    end
  endtask
  function automatic logic ok(input logic [7:0] a);
    ok = a <= 8'h20 && a[1:0] == 2'h0;
  endfunction
  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      8'h00, 8'h08: msk = 32'hF;
      8'h04: msk = 32'hFF;
      8'h0C: msk = 32'hFFFF;
      8'h10: msk = 32'h7F;
      8'h20: msk = 32'h7;
      default: msk = 32'h0;
    endcase
  endfunction
  function automatic logic sel(input int w);
    case (w)
      0: sel = lclk;
      1: sel = bpwm;
      2: sel = bsy_o;
      default: sel = lsy_o;
    endcase
  endfunction
  task w(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk_in);
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", bresp, ok(a) ? 2'h0 : 2'h2);
    if (ok(a))
      exp_q[a[5:2]] = d & msk(a);
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk_in); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk_in); while (rvalid !== 1'h1);
    rready <= 1'h0;
    rd_q = rdata;
    chk("rresp", rresp, ok(a) ? 2'h0 : 2'h2);
  endtask
  task per(input int s, input int e);
    int k, c, n;
    logic p;
    repeat (2)
    begin
      k = 0;
      c = 0;
      n = 0;
      p = sel(s);
      while (k < 2 && n < 9000)
      begin
        @(posedge clk_in);
        n++;
        if (sel(s) === 1'h1 && p !== 1'h1)
          k++;
        if (k == 1)
          c++;
        p = sel(s);
      end
    end
    chk("period", c, e);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    err_total++;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(32'hAFBF));
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'h1;
    w(10);
    chk("strikes", strikes, 1);
    chk("lamp", lamp_en, 1);
    for (int a = 0; a < 36; a += 4)
      if (a != 20 && a != 24)
      begin
        rd(a[7:0]);
        chk("reg", rd_q, exp_q[a / 4]);
      end
    rd(8'h40);
    chk("unmapped", rd_q, 0);
    wr(8'h40, 32'h1);
    repeat (4)
    begin
      adr_q <= 1'($urandom);
      w(5);
      chk("addr", adr_o, adr_q);
    end
    $display("end registers");
    off_q <= 1'h1;
    w(8);
    chk("lamp", lamp_en, 0);
    off_q <= 1'h0;
    w(8);
    chk("lamp", lamp_en, 1);
    chk("strikes", strikes, 2);
    wr(8'h00, 32'h1);
    w(3);
    chk("lamp", lamp_en, 0);
    wr(8'h00, 32'h0);
    w(3);
    chk("strikes", strikes, 3);
    rd(8'h18);
    chk("status", rd_q, 5);
    wr(8'h20, 32'h1);
    w(2);
    chk("irq", irq, 1);
    wr(8'h1C, 32'h1);
    w(2);
    chk("irq", irq, 0);
    rd(8'h18);
    chk("status", rd_q, 4);
    wr(8'h20, 32'h4);
    w(2);
    chk("irq", irq, 1);
    wr(8'h1C, 32'h7);
    w(2);
    chk("irq", irq, 0);
    $display("end lamp control");
    amt = 4'($urandom);
    wr(8'h04, {24'h0, amt, 4'h0});
    ovd_q <= 1'h1;
    w(5);
    chk("ovd", {ovd_act, ovd_amt}, {1'h1, amt});
    ovd_q <= 1'h0;
    w(5);
    chk("ovd", {ovd_act, ovd_amt}, 0);
    wr(8'h04, {24'h0, amt, 4'h1});
    w(2);
    chk("ovd", {ovd_act, ovd_amt}, {1'h1, amt});
    wr(8'h04, 32'h0);
    flt_q <= 1'h1;
    w(8);
    flt_q <= 1'h0;
    w(4);
    chk("fault", {fn_oe, fn}, 2);
    rd(8'h18);
    chk("status", rd_q, 2);
    off_q <= 1'h1;
    w(8);
    chk("fault", fn_oe, 0);
    off_q <= 1'h0;
    $display("end overdrive and fault");
    wr(8'h0C, 32'd100);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h08, {28'h0, i[2:1], i[0], ~i[1]});
      shf_q <= i[1];
      per(0, 2 * (i[0] ? 99 - i[2:1] : 101 + i[2:1]));
    end
    wr(8'h08, 32'h0);
    shf_q <= 1'h0;
    per(3, 200);
    chk("oe", {lsy_oe, bsy_oe}, 3);
    wr(8'h10, 32'h5);
    wr(8'h00, 32'h6);
    w(3);
    chk("oe", {lsy_oe, bsy_oe}, 0);
    per(0, 14);
    per(1, 46);
    wr(8'h00, 32'h8);
    osc_run <= 1'h1;
    per(1, 40);
    per(2, 40);
    osc_run <= 1'h0;
    wr(8'h00, 32'h0);
    per(1, 128 * STEP);
    $display("end frequency and sync");
    off_q <= 1'h1;
    arst_n_in <= 1'h0;
    w(3);
    arst_n_in <= 1'h1;
    w(10);
    chk("lamp", lamp_en, 0);
    chk("strikes", strikes, 4);
    off_q <= 1'h0;
    w(8);
    chk("lamp", lamp_en, 1);
    chk("strikes", strikes, 5);
    $display("end reset");
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
